// [rtl/samc_access_ctrl.sv]
// samc_access_ctrl: access modes, key sequence check and permission gating
// assumes control command writes arrive as one-cycle strobes with 16-bit data
`timescale 1ns/1ns
module samc_access_ctrl
    import samc_pkg::*;
(
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic ctl_wr,
    input wire logic [15:0] ctl_data,
    input wire logic key_wr,
    input wire logic [1:0] key_idx,
    input wire logic [15:0] key_data,
    input wire logic acc_req,
    input wire logic acc_write,
    input wire logic acc_private,
    input wire logic acc_info_a,
    output logic acc_grant,
    output logic acc_deny,
    output logic locked_mode_bit,
    output logic full_access_locked_mode_bit,
    output logic [1:0] mode,
    output logic boot_rom_mode
);
    typedef enum logic [1:0] {SAMC_SEQ_IDLE, SAMC_SEQ_FETCH, SAMC_SEQ_HAVE1} samc_seq_e;
    samc_mode_e mode_r, mode_nxt;
    samc_seq_e seq_r, seq_nxt;
    logic [15:0] first_r, first_nxt;
    logic [15:0] second_r, second_nxt;
    logic [1:0] rd_idx_r, rd_idx_nxt;
    logic u_ok_r, u_ok_nxt;
    logic p_ok_r, p_ok_nxt;
    logic grant_r, grant_nxt;
    logic deny_r, deny_nxt;
    logic ss_r, ss_nxt;
    logic fas_r, fas_nxt;
    logic boot_r, boot_nxt;
    logic [15:0] key_rd;
    logic key_store_wr;
    logic [15:0] swapped;

    assign key_store_wr = key_wr && (mode_r == SAMC_PRIVILEGED);
    assign swapped = {ctl_data[7:0], ctl_data[15:8]};

    samc_key_store u_keys (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .wr_en(key_store_wr),
        .wr_idx(key_idx),
        .wr_data(key_data),
        .rd_idx(rd_idx_r),
        .rd_data(key_rd)
    );

    // sequence: two words taken, then four fetch cycles compare against stored keys
    always_comb begin
        seq_nxt = seq_r;
        first_nxt = first_r;
        second_nxt = second_r;
        rd_idx_nxt = rd_idx_r;
        u_ok_nxt = u_ok_r;
        p_ok_nxt = p_ok_r;
        mode_nxt = mode_r;
        case (seq_r)
            SAMC_SEQ_IDLE: begin
                if (ctl_wr) begin
                    if (ctl_data == SAMC_CMD_LOCK) begin
                        mode_nxt = SAMC_LOCKED;
                    end else if (ctl_data == SAMC_CMD_BOOT_ROM) begin
                        // refused outside privileged and never taken as a key word
                        if (mode_r == SAMC_PRIVILEGED) begin
                            mode_nxt = SAMC_BOOT_ROM;
                        end
                    end else begin
                        first_nxt = swapped;
                        rd_idx_nxt = SAMC_KEY_UNLOCK0;
                        seq_nxt = SAMC_SEQ_HAVE1;
                    end
                end
            end
            SAMC_SEQ_HAVE1: begin
                // rd_idx_r sits at word 0 here, so key_rd is ready when fetch starts
                if (ctl_wr) begin
                    if (ctl_data == SAMC_CMD_LOCK || ctl_data == SAMC_CMD_BOOT_ROM) begin
                        seq_nxt = SAMC_SEQ_IDLE;
                        if (ctl_data == SAMC_CMD_LOCK) begin
                            mode_nxt = SAMC_LOCKED;
                        end else if (mode_r == SAMC_PRIVILEGED) begin
                            mode_nxt = SAMC_BOOT_ROM;
                        end
                    end else begin
                        second_nxt = swapped;
                        rd_idx_nxt = SAMC_KEY_UNLOCK1;
                        u_ok_nxt = 1'b1;
                        p_ok_nxt = 1'b1;
                        seq_nxt = SAMC_SEQ_FETCH;
                    end
                end
            end
            SAMC_SEQ_FETCH: begin
                // key_rd holds word at rd_idx_r-1 once rd_idx advances; walk 4 words
                if (ctl_wr) begin
                    seq_nxt = SAMC_SEQ_IDLE;
                end else begin
                    rd_idx_nxt = rd_idx_r + 2'h1;
                    if (rd_idx_r == SAMC_KEY_UNLOCK1) begin
                        u_ok_nxt = u_ok_r && (key_rd == first_r);
                    end else if (rd_idx_r == SAMC_KEY_PRIV0) begin
                        u_ok_nxt = u_ok_r && (key_rd == second_r);
                    end else if (rd_idx_r == SAMC_KEY_PRIV1) begin
                        p_ok_nxt = p_ok_r && (key_rd == first_r);
                    end else begin
                        seq_nxt = SAMC_SEQ_IDLE;
                        if (p_ok_r && key_rd == second_r && mode_r == SAMC_UNLOCKED) begin
                            mode_nxt = SAMC_PRIVILEGED;
                        end else if (u_ok_r && mode_r == SAMC_LOCKED) begin
                            mode_nxt = SAMC_UNLOCKED;
                        end
                    end
                end
            end
            default: seq_nxt = SAMC_SEQ_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            seq_r <= SAMC_SEQ_IDLE;
            first_r <= 16'h0000;
            second_r <= 16'h0000;
            rd_idx_r <= 2'h0;
            u_ok_r <= 1'b0;
            p_ok_r <= 1'b0;
            mode_r <= SAMC_LOCKED;
        end else begin
            seq_r <= seq_nxt;
            first_r <= first_nxt;
            second_r <= second_nxt;
            rd_idx_r <= rd_idx_nxt;
            u_ok_r <= u_ok_nxt;
            p_ok_r <= p_ok_nxt;
            mode_r <= mode_nxt;
        end
    end

    // permission and status bits
    always_comb begin
        grant_nxt = 1'b0;
        deny_nxt = 1'b0;
        if (acc_req) begin
            if (mode_r == SAMC_UNLOCKED || mode_r == SAMC_PRIVILEGED) begin
                grant_nxt = 1'b1;
            end else if (mode_r == SAMC_LOCKED && !acc_write && !acc_private) begin
                grant_nxt = 1'b1;
            end else if (mode_r == SAMC_LOCKED && acc_write && acc_info_a) begin
                deny_nxt = 1'b1;
            end else begin
                deny_nxt = 1'b1;
            end
        end
        ss_nxt = (mode_nxt == SAMC_LOCKED);
        fas_nxt = (mode_nxt != SAMC_PRIVILEGED);
        boot_nxt = (mode_nxt == SAMC_BOOT_ROM);
    end

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            grant_r <= 1'b0;
            deny_r <= 1'b0;
            ss_r <= 1'b1;
            fas_r <= 1'b1;
            boot_r <= 1'b0;
        end else begin
            grant_r <= grant_nxt;
            deny_r <= deny_nxt;
            ss_r <= ss_nxt;
            fas_r <= fas_nxt;
            boot_r <= boot_nxt;
        end
    end

    assign acc_grant = grant_r;
    assign acc_deny = deny_r;
    assign locked_mode_bit = ss_r;
    assign full_access_locked_mode_bit = fas_r;
    assign mode = mode_r;
    assign boot_rom_mode = boot_r;

    sequence s_locked_write;
        acc_req && acc_write && (mode_r == SAMC_LOCKED);
    endsequence
    a_locked_write_deny: assert property (@(posedge sys_clk) disable iff (!resetn)
        s_locked_write |=> deny_r && !grant_r) else $error("write granted while locked");
    a_locked_private_deny: assert property (@(posedge sys_clk) disable iff (!resetn)
        acc_req && acc_private && mode_r == SAMC_LOCKED |=> !grant_r) else $error("private read while locked");
    a_open_mode_grant: assert property (@(posedge sys_clk) disable iff (!resetn)
        acc_req && (mode_r == SAMC_UNLOCKED || mode_r == SAMC_PRIVILEGED) |=> grant_r)
        else $error("access refused in open mode");
    a_boot_only_priv: assert property (@(posedge sys_clk) disable iff (!resetn)
        mode_r == SAMC_BOOT_ROM && $past(mode_r) != SAMC_BOOT_ROM |-> $past(mode_r) == SAMC_PRIVILEGED)
        else $error("boot rom mode from wrong mode");
    a_key_write_gate: assert property (@(posedge sys_clk) disable iff (!resetn)
        key_store_wr |-> mode_r == SAMC_PRIVILEGED) else $error("key written outside privileged");
    a_locked_mode_tracks: assert property (@(posedge sys_clk) disable iff (!resetn)
        ss_r == (mode_r == SAMC_LOCKED)) else $error("locked_mode bit wrong");
    a_fas_tracks: assert property (@(posedge sys_clk) disable iff (!resetn)
        fas_r == (mode_r != SAMC_PRIVILEGED)) else $error("full access locked_mode bit wrong");
    a_abort_keeps: assert property (@(posedge sys_clk) disable iff (!resetn)
        seq_r == SAMC_SEQ_FETCH && ctl_wr |=> seq_r == SAMC_SEQ_IDLE && $stable(mode_r))
        else $error("interrupted sequence changed mode");
    a_unlock_from_locked: assert property (@(posedge sys_clk) disable iff (!resetn)
        mode_r == SAMC_UNLOCKED && $past(mode_r) == SAMC_LOCKED |-> $past(seq_r) == SAMC_SEQ_FETCH)
        else $error("unlock without key sequence");
endmodule // samc_access_ctrl

// [rtl/samc_key_store.sv]
// samc_key_store: four 16-bit key words, registered read data
// assumes writes come already permitted by the controller
`timescale 1ns/1ns
module samc_key_store
    import samc_pkg::*;
(
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic wr_en,
    input wire logic [1:0] wr_idx,
    input wire logic [15:0] wr_data,
    input wire logic [1:0] rd_idx,
    output logic [15:0] rd_data
);
    localparam logic [15:0] RST_VAL [4] = '{SAMC_UNLOCK_KEY0_RST, SAMC_UNLOCK_KEY1_RST,
                                            SAMC_PRIV_KEY0_RST, SAMC_PRIV_KEY1_RST};
    logic [15:0] key_r [4];
    logic [15:0] key_nxt [4];
    logic [15:0] rd_data_r;
    logic [15:0] rd_data_nxt;
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_key
            always_comb begin
                key_nxt[gi] = key_r[gi];
                if (wr_en && wr_idx == 2'(gi)) begin
                    key_nxt[gi] = wr_data;
                end
            end
            always_ff @(posedge sys_clk) begin
                if (!resetn) begin
                    key_r[gi] <= RST_VAL[gi];
                end else begin
                    key_r[gi] <= key_nxt[gi];
                end
            end
        end
    endgenerate
    always_comb begin
        rd_data_nxt = key_r[rd_idx];
    end
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            rd_data_r <= 16'h0000;
        end else begin
            rd_data_r <= rd_data_nxt;
        end
    end
    assign rd_data = rd_data_r;
endmodule // samc_key_store

// [rtl/samc_pkg.sv]
// samc_pkg: constants and types for the security access mode controller
// assumes one 100 MHz system clock domain
package samc_pkg;
    typedef enum logic [1:0] {
        SAMC_LOCKED,
        SAMC_UNLOCKED,
        SAMC_PRIVILEGED,
        SAMC_BOOT_ROM
    } samc_mode_e;
    localparam logic [15:0] SAMC_UNLOCK_KEY0_RST = 16'h0414;
    localparam logic [15:0] SAMC_UNLOCK_KEY1_RST = 16'h3672;
    localparam logic [15:0] SAMC_PRIV_KEY0_RST = 16'hFFFF;
    localparam logic [15:0] SAMC_PRIV_KEY1_RST = 16'hFFFF;
    localparam logic [1:0] SAMC_KEY_UNLOCK0 = 2'h0;
    localparam logic [1:0] SAMC_KEY_UNLOCK1 = 2'h1;
    localparam logic [1:0] SAMC_KEY_PRIV0 = 2'h2;
    localparam logic [1:0] SAMC_KEY_PRIV1 = 2'h3;
    localparam logic [15:0] SAMC_CMD_LOCK = 16'h0020;
    localparam logic [15:0] SAMC_CMD_BOOT_ROM = 16'h0F00;
endpackage

// [verif/samc_host_model.sv]
// samc_host_model: host side that writes words to the control command
// assumes the controller samples ctl_wr on the rising edge of sys_clk
`timescale 1ns/1ns
module samc_host_model (
    input wire logic sys_clk,
    output logic ctl_wr,
    output logic [15:0] ctl_data
);
    initial begin
        ctl_wr = 1'b0;
        ctl_data = 16'h0000;
    end
    // one control write, raised just after an edge
    task automatic put(input logic [15:0] w);
        @(posedge sys_clk);
        ctl_wr <= 1'b1;
        ctl_data <= w;
    endtask
    // release after the sampling edge; data no longer shows the last word
    task automatic idle(input int n);
        @(posedge sys_clk);
        ctl_wr <= 1'b0;
        ctl_data <= ~ctl_data;
        repeat (n) @(posedge sys_clk);
    endtask
    // key words sent byte swapped, back to back, then the compare time passes
    task automatic key_pair(input logic [15:0] k0, input logic [15:0] k1);
        put({k0[7:0], k0[15:8]});
        put({k1[7:0], k1[15:8]});
        idle(8);
    endtask
endmodule // samc_host_model

// [verif/security_access_mode_control_bench.sv]
// security_access_mode_control_bench: self-checking bench for samc_access_ctrl
// assumes samc_pkg and the host model are compiled first
`timescale 1ns/1ns
module security_access_mode_control_bench;
    import samc_pkg::*;
    logic sys_clk, resetn, ctl_wr, key_wr, acc_req, acc_write, acc_private, acc_info_a;
    logic [15:0] ctl_data, key_data, nk0, nk1;
    logic [1:0] key_idx, mode;
    logic acc_grant, acc_deny, locked_mode_bit, full_access_locked_mode_bit, boot_rom_mode;
    logic exp_q[$];
    int n_fail, tests_run, cyc;
    integer seed;
    samc_host_model i_samc_host_model (.sys_clk(sys_clk), .ctl_wr(ctl_wr), .ctl_data(ctl_data));
    samc_access_ctrl i_samc_access_ctrl (.sys_clk(sys_clk), .resetn(resetn), .ctl_wr(ctl_wr),
        .ctl_data(ctl_data), .key_wr(key_wr), .key_idx(key_idx), .key_data(key_data),
        .acc_req(acc_req), .acc_write(acc_write), .acc_private(acc_private), .acc_info_a(acc_info_a),
        .acc_grant(acc_grant), .acc_deny(acc_deny), .locked_mode_bit(locked_mode_bit),
        .full_access_locked_mode_bit(full_access_locked_mode_bit), .mode(mode), .boot_rom_mode(boot_rom_mode));
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    task automatic test_done();
        n_fail += exp_q.size();
        $display("checks %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic chk_acc(input logic [1:0] exp, input logic [1:0] got);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("Error grant_deny expected %h seen %h", exp, got);
        end
    endtask
    // mode, locked_mode, full access locked_mode and boot rom flag as one word
    task automatic chk_state(input samc_mode_e m);
        logic [4:0] exp;
        exp = {m, m == SAMC_LOCKED, m != SAMC_PRIVILEGED, m == SAMC_BOOT_ROM};
        @(negedge sys_clk);
        tests_run++;
        if ({mode, locked_mode_bit, full_access_locked_mode_bit, boot_rom_mode} !== exp) begin
            n_fail++;
            $display("Error state expected %h seen %h", exp,
                {mode, locked_mode_bit, full_access_locked_mode_bit, boot_rom_mode});
        end
    endtask
    task automatic acc(input logic [2:0] k, input logic g);
        @(posedge sys_clk);
        {acc_write, acc_private, acc_info_a} <= k;
        acc_req <= 1'b1;
        exp_q.push_back(g);
        @(posedge sys_clk);
        acc_req <= 1'b0;
    endtask
    // every write, private and block a combination; locked allows plain reads only
    task automatic sweep(input logic lk);
        for (int i = 0; i < 8; i++) acc(i[2:0], !lk || (i[2:1] == 2'b00));
        repeat (3) @(posedge sys_clk);
    endtask
    task automatic kw(input logic [1:0] idx, input logic [15:0] d);
        @(posedge sys_clk);
        key_wr <= 1'b1;
        key_idx <= idx;
        key_data <= d;
        @(posedge sys_clk);
        key_wr <= 1'b0;
    endtask
    always @(posedge sys_clk) begin
        if (resetn && (acc_grant || acc_deny)) begin
            if (exp_q.size() == 0) chk_acc(2'b00, {acc_grant, acc_deny});
            else chk_acc({exp_q[0], !exp_q[0]}, {acc_grant, acc_deny});
            if (exp_q.size() != 0) void'(exp_q.pop_front());
        end
    end
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 5000) begin
            n_fail++;
            test_done();
        end
    end
    initial begin
        seed = 5623;
        n_fail = 0;
        tests_run = 0;
        cyc = 0;
        resetn = 1'b0;
        key_wr = 1'b0;
        key_idx = 2'h0;
        key_data = 16'h0000;
        acc_req = 1'b0;
        acc_write = 1'b0;
        acc_private = 1'b0;
        acc_info_a = 1'b0;
        repeat (8) @(posedge sys_clk);
        resetn <= 1'b1;
        chk_state(SAMC_LOCKED);
        sweep(1'b1);
        nk0 = $random(seed) | 16'h8000;
        nk1 = $random(seed) | 16'h8000;
        kw(SAMC_KEY_UNLOCK0, nk0);
        i_samc_host_model.key_pair(SAMC_UNLOCK_KEY0_RST, ~SAMC_UNLOCK_KEY1_RST);
        chk_state(SAMC_LOCKED);
        i_samc_host_model.put({SAMC_UNLOCK_KEY0_RST[7:0], SAMC_UNLOCK_KEY0_RST[15:8]});
        i_samc_host_model.put(SAMC_CMD_LOCK);
        i_samc_host_model.put({SAMC_UNLOCK_KEY1_RST[7:0], SAMC_UNLOCK_KEY1_RST[15:8]});
        i_samc_host_model.put(SAMC_CMD_LOCK);
        i_samc_host_model.idle(8);
        chk_state(SAMC_LOCKED);
        i_samc_host_model.put({SAMC_UNLOCK_KEY0_RST[7:0], SAMC_UNLOCK_KEY0_RST[15:8]});
        i_samc_host_model.put({SAMC_UNLOCK_KEY1_RST[7:0], SAMC_UNLOCK_KEY1_RST[15:8]});
        i_samc_host_model.put({SAMC_UNLOCK_KEY0_RST[7:0], SAMC_UNLOCK_KEY0_RST[15:8]});
        i_samc_host_model.idle(8);
        chk_state(SAMC_LOCKED);
        i_samc_host_model.key_pair(SAMC_UNLOCK_KEY0_RST, SAMC_UNLOCK_KEY1_RST);
        chk_state(SAMC_UNLOCKED);
        sweep(1'b0);
        i_samc_host_model.put(SAMC_CMD_BOOT_ROM);
        i_samc_host_model.idle(8);
        chk_state(SAMC_UNLOCKED);
        kw(SAMC_KEY_PRIV0, nk0);
        i_samc_host_model.key_pair(SAMC_PRIV_KEY0_RST, SAMC_PRIV_KEY1_RST);
        chk_state(SAMC_PRIVILEGED);
        kw(SAMC_KEY_UNLOCK0, nk0);
        kw(SAMC_KEY_UNLOCK1, nk1);
        i_samc_host_model.put(SAMC_CMD_LOCK);
        i_samc_host_model.idle(8);
        chk_state(SAMC_LOCKED);
        i_samc_host_model.key_pair(SAMC_UNLOCK_KEY0_RST, SAMC_UNLOCK_KEY1_RST);
        chk_state(SAMC_LOCKED);
        i_samc_host_model.key_pair(nk0, nk1);
        chk_state(SAMC_UNLOCKED);
        i_samc_host_model.key_pair(SAMC_PRIV_KEY0_RST, SAMC_PRIV_KEY1_RST);
        i_samc_host_model.put(SAMC_CMD_BOOT_ROM);
        i_samc_host_model.idle(8);
        chk_state(SAMC_BOOT_ROM);
        test_done();
    end
endmodule // security_access_mode_control_bench
